// >>> inc/tdc_map.vh
// Register map, field positions and reset values of the drift corrector
`ifndef TDC_MAP_VH
`define TDC_MAP_VH

`define TDC_AW          8
`define TDC_DW          24
`define TDC_FRAC        20

`define TDC_A_CFG1      8'h01
`define TDC_A_VPR       8'h07
`define TDC_A_GAIN      8'h08
`define TDC_A_OFFS      8'h09
`define TDC_A_STAT      8'h10
`define TDC_A_RESULT    8'h11
`define TDC_A_TEMP      8'h12

`define TDC_B_TEMP_EN   6
`define TDC_B_SRC_SEL   8
`define TDC_B_VPR_EN    11
`define TDC_CFG1_MASK   24'h000940

`define TDC_B_ST_BUSY   0
`define TDC_B_ST_OVR    1
`define TDC_B_ST_SAT    2

`define TDC_RST_CFG1    24'h000000
`define TDC_RST_VPR     24'h000000
`define TDC_RST_GAIN    24'h000000
`define TDC_RST_OFFS    24'h000000

`endif

// >>> core/tdc_mul.v
// Signed fixed-point multiplier with saturation
`timescale 1ns/1ps
`default_nettype none

module tdc_mul #(
	parameter W = 24,
	parameter F = 20
) (
	// Operands, fixed point with F fraction bits
	input  wire signed [W-1:0] a,
	input  wire signed [W-1:0] b,
	// Product, same format, clamped
	output reg  signed [W-1:0] p,
	output reg                 sat
);

	wire signed [2*W-1:0] full;
	wire        [2*W-F-1:0] sh;

	assign full = a * b;
	assign sh   = full[2*W-1:F];

	// Clamp when the upper bits are not a sign extension
	always @* begin
		p   = sh[W-1:0];
		sat = 1'b0;
		if (sh[2*W-F-1:W-1] != {(W-F+1){sh[W-1]}}) begin
			sat = 1'b1;
			p   = sh[2*W-F-1] ? {1'b1, {(W-1){1'b0}}}
			                  : {1'b0, {(W-1){1'b1}}};
		end
	end

endmodule // tdc_mul

`default_nettype wire

// >>> core/tdc_top.v
// Temperature drift corrector for the bridge result
// What this block does
// - Correction applied only while enable bit set
// - Source bit picks span or on-chip reference
// - Gain and offset factors from 24-bit words
// - Span reference corrects gain and zero drift
// - On-chip reference uses the same two factors
// - Virtual parallel resistor shapes reference when enabled
// - Resistor multiple is signed, minus eight upward
// - Temperature ratio published with result, cycle end
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tdc_map.vh"

module tdc_top #(
	parameter W = `TDC_DW,
	parameter F = `TDC_FRAC
) (
	// Clock and reset
	input  wire          mclk,
	input  wire          nrst,
	// Register port
	input  wire [7:0]    addr,
	input  wire [W-1:0]  wdata,
	input  wire          wr,
	input  wire          rd,
	output reg  [W-1:0]  rdata_q,
	// Raw measurements at the end of a cycle
	input  wire          cycle_end,
	input  wire [W-1:0]  bridge_raw,
	input  wire [W-1:0]  span_ratio,
	input  wire [W-1:0]  chip_temp_ratio,
	// Published results
	output reg  [W-1:0]  result_q,
	output reg  [W-1:0]  temp_res_q,
	output reg           result_valid_q,
	output wire          busy
);

	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_SQ   = 3'd1;
	localparam [2:0] S_VP   = 3'd2;
	localparam [2:0] S_GN   = 3'd3;
	localparam [2:0] S_RW   = 3'd4;
	localparam [2:0] S_OF   = 3'd5;
	localparam [2:0] S_DONE = 3'd6;

	reg  [W-1:0] cfg1_q;
	reg  [W-1:0] vpr_q;
	reg  [W-1:0] gain_q;
	reg  [W-1:0] offs_q;
	reg          ovr_q;
	reg          sat_q;
	reg  [2:0]   state_q;
	reg  [2:0]   state_d;
	reg  [W-1:0] raw_q;
	reg  [W-1:0] tref_q;
	reg  [W-1:0] tmp_q;
	reg  [W-1:0] teff_q;
	reg  [W-1:0] acc_q;
	reg  [W-1:0] temp_hold_q;
	reg          en_q;
	reg  [W-1:0] mul_a;
	reg  [W-1:0] mul_b;
	wire [W-1:0] mul_p;
	wire         mul_sat;
	wire         start;
	wire         wr_stat;
	wire         en_next;
	wire         vpr_next;

	assign busy    = (state_q != S_IDLE);
	assign start   = cycle_end && !busy;
	assign wr_stat = wr && (addr == `TDC_A_STAT);

	// Saturating sum used when the correction terms are added
	function [W-1:0] sat_add;
		input [W-1:0] x;
		input [W-1:0] y;
		reg   [W:0]   s;
		begin
			s = {x[W-1], x} + {y[W-1], y};
			if (s[W] != s[W-1])
				sat_add = s[W] ? {1'b1, {(W-1){1'b0}}}
				               : {1'b0, {(W-1){1'b1}}};
			else
				sat_add = s[W-1:0];
		end
	endfunction

	// Register writes
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cfg1_q <= `TDC_RST_CFG1;
			vpr_q  <= `TDC_RST_VPR;
			gain_q <= `TDC_RST_GAIN;
			offs_q <= `TDC_RST_OFFS;
		end else if (wr) begin
			case (addr)
				`TDC_A_CFG1: cfg1_q <= wdata & `TDC_CFG1_MASK;
				`TDC_A_VPR:  vpr_q  <= wdata;
				`TDC_A_GAIN: gain_q <= wdata;
				`TDC_A_OFFS: offs_q <= wdata;
				default: ;
			endcase
		end
	end

	// Register reads, data one cycle after the strobe
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= {W{1'b0}};
		end else if (rd) begin
			case (addr)
				`TDC_A_CFG1:   rdata_q <= cfg1_q;
				`TDC_A_VPR:    rdata_q <= vpr_q;
				`TDC_A_GAIN:   rdata_q <= gain_q;
				`TDC_A_OFFS:   rdata_q <= offs_q;
				`TDC_A_STAT:   rdata_q <= {{(W-3){1'b0}}, sat_q, ovr_q,
				                           busy};
				`TDC_A_RESULT: rdata_q <= result_q;
				`TDC_A_TEMP:   rdata_q <= temp_res_q;
				default:       rdata_q <= {W{1'b0}};
			endcase
		end else begin
			rdata_q <= {W{1'b0}};
		end
	end

	// Sticky flags, cleared by writing one; a new event wins
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ovr_q <= 1'b0;
			sat_q <= 1'b0;
		end else begin
			if (cycle_end && busy)
				ovr_q <= 1'b1;
			else if (wr_stat && wdata[`TDC_B_ST_OVR])
				ovr_q <= 1'b0;
			if (busy && state_q != S_DONE && mul_sat)
				sat_q <= 1'b1;
			else if (wr_stat && wdata[`TDC_B_ST_SAT])
				sat_q <= 1'b0;
		end
	end

	// Operand selection for the shared multiplier
	always @* begin
		mul_a = tref_q;
		mul_b = tref_q;
		case (state_q)
			S_SQ: begin
				mul_a = tref_q;
				mul_b = tref_q;
			end
			S_VP: begin
				mul_a = tmp_q;
				mul_b = vpr_q;
			end
			S_GN: begin
				mul_a = gain_q;
				mul_b = teff_q;
			end
			S_RW: begin
				mul_a = raw_q;
				mul_b = tmp_q;
			end
			S_OF: begin
				mul_a = offs_q;
				mul_b = teff_q;
			end
			default: begin
				mul_a = tref_q;
				mul_b = tref_q;
			end
		endcase
	end

	tdc_mul #(
		.W (W),
		.F (F)
	) u_mul (
		.a   (mul_a),
		.b   (mul_b),
		.p   (mul_p),
		.sat (mul_sat)
	);

	// Sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
			S_IDLE: if (start)
				state_d = en_next ? (vpr_next ? S_SQ : S_GN) : S_DONE;
			S_SQ:   state_d = S_VP;
			S_VP:   state_d = S_GN;
			S_GN:   state_d = S_RW;
			S_RW:   state_d = S_OF;
			S_OF:   state_d = S_DONE;
			S_DONE: state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	assign en_next  = cfg1_q[`TDC_B_TEMP_EN];
	assign vpr_next = cfg1_q[`TDC_B_VPR_EN];

	// Datapath
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q        <= S_IDLE;
			raw_q          <= {W{1'b0}};
			tref_q         <= {W{1'b0}};
			tmp_q          <= {W{1'b0}};
			teff_q         <= {W{1'b0}};
			acc_q          <= {W{1'b0}};
			temp_hold_q    <= {W{1'b0}};
			en_q           <= 1'b0;
			result_q       <= {W{1'b0}};
			temp_res_q     <= {W{1'b0}};
			result_valid_q <= 1'b0;
		end else begin
			state_q        <= state_d;
			result_valid_q <= 1'b0;
			case (state_q)
				S_IDLE: if (start) begin
					raw_q       <= bridge_raw;
					acc_q       <= bridge_raw;
					en_q        <= en_next;
					temp_hold_q <= chip_temp_ratio;
					if (cfg1_q[`TDC_B_SRC_SEL]) begin
						tref_q <= chip_temp_ratio;
						teff_q <= chip_temp_ratio;
					end else begin
						tref_q <= span_ratio;
						teff_q <= span_ratio;
					end
				end
				S_SQ: tmp_q <= mul_p;
				S_VP: teff_q <= sat_add(tref_q,
				                        ~mul_p + {{(W-1){1'b0}}, 1'b1});
				S_GN: tmp_q <= mul_p;
				S_RW: acc_q <= sat_add(acc_q, mul_p);
				S_OF: acc_q <= sat_add(acc_q, mul_p);
				S_DONE: begin
					result_q       <= en_q ? acc_q : raw_q;
					temp_res_q     <= temp_hold_q;
					result_valid_q <= 1'b1;
				end
				default: ;
			endcase
		end
	end

endmodule // tdc_top

`default_nettype wire

// >>> test/tdc_top_asserts.sv
// Assertions for the drift corrector
`timescale 1ns/1ps
`default_nettype none
module tdc_chk (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// Register port
	input wire logic [7:0]  addr,
	input wire logic [23:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [23:0] rdata_q,
	// Measurement path
	input wire logic        cycle_end,
	input wire logic [23:0] bridge_raw,
	input wire logic [23:0] span_ratio,
	input wire logic [23:0] chip_temp_ratio,
	input wire logic [23:0] result_q,
	input wire logic [23:0] temp_res_q,
	input wire logic        result_valid_q,
	input wire logic        busy
);
	logic [23:0] cfg_q;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			cfg_q <= 24'h000000;
		else if (wr && addr == 8'h01)
			cfg_q <= wdata;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_take; cycle_end && !busy; endsequence
	sequence s_wr_rd; wr && addr == 8'h08 ##1 !wr ##1 rd && addr == 8'h08;
	endsequence
	property p_rdg; s_wr_rd |=> rdata_q == $past(wdata, 3); endproperty
	a_rdg: assert property (p_rdg) else $error("gain readback");
	property p_rdz; !rd |=> rdata_q == 24'h000000; endproperty
	a_rdz: assert property (p_rdz) else $error("idle rdata");
	property p_off; s_take ##0 !cfg_q[6] |->
		##2 result_valid_q && result_q == $past(bridge_raw, 2); endproperty
	a_off: assert property (p_off) else $error("bypass result");
	property p_on; s_take ##0 cfg_q[6] && !cfg_q[11] |->
		##[5:6] result_valid_q; endproperty
	a_on: assert property (p_on) else $error("corrected latency");
	property p_vpr; s_take ##0 cfg_q[6] && cfg_q[11] |->
		##[7:8] result_valid_q; endproperty
	a_vpr: assert property (p_vpr) else $error("resistor latency");
	property p_busy; s_take ##0 cfg_q[6] |=> busy [*4]; endproperty
	a_busy: assert property (p_busy) else $error("busy drop");
	property p_res; $changed(result_q) |-> result_valid_q; endproperty
	a_res: assert property (p_res) else $error("result moved");
	property p_tmp; $changed(temp_res_q) |-> result_valid_q; endproperty
	a_tmp: assert property (p_tmp) else $error("temp moved");
endmodule // tdc_chk
bind tdc_top tdc_chk chk_u (.mclk(mclk), .nrst(nrst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
	.cycle_end(cycle_end), .bridge_raw(bridge_raw),
	.span_ratio(span_ratio), .chip_temp_ratio(chip_temp_ratio),
	.result_q(result_q), .temp_res_q(temp_res_q),
	.result_valid_q(result_valid_q), .busy(busy));
`default_nettype wire

// >>> test/temp_drift_compensation_tb_top.sv
// Bench for the drift corrector
`timescale 1ns/1ps
`default_nettype none
module temp_drift_compensation_tb_top;
	logic        mclk = 0, nrst = 0, wr = 0, rd = 0, cycle_end = 0;
	logic [7:0]  addr = 0;
	logic [23:0] wdata = 0, bridge_raw = 0;
	logic [23:0] span_ratio = 0, chip_temp_ratio = 0;
	wire  [23:0] rdata_q, result_q, temp_res_q;
	wire         result_valid_q, busy;
	int          mismatches = 0, check_count = 0;
	always #5 mclk = ~mclk;
	tdc_top dut_u (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_q(rdata_q), .cycle_end(cycle_end),
		.bridge_raw(bridge_raw), .span_ratio(span_ratio),
		.chip_temp_ratio(chip_temp_ratio), .result_q(result_q),
		.temp_res_q(temp_res_q), .result_valid_q(result_valid_q),
		.busy(busy));
	task automatic chk(string n, logic [23:0] s, logic [23:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wreg(logic [7:0] a, logic [23:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge mclk);
		wr <= 0;
		@(posedge mclk);
	endtask
	task automatic rchk(logic [7:0] a, logic [23:0] e);
		addr <= a;
		rd <= 1;
		@(posedge mclk);
		rd <= 0;
		#1;
		chk("rdata", rdata_q, e);
		@(posedge mclk);
	endtask
	task automatic meas(logic [23:0] sp, ch, raw, e);
		span_ratio <= sp;
		chip_temp_ratio <= ch;
		bridge_raw <= raw;
		cycle_end <= 1;
		@(posedge mclk);
		cycle_end <= 0;
		for (int i = 0; i < 20 && result_valid_q !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		if (result_valid_q !== 1'b1) begin
			mismatches++;
			summarize();
		end
		chk("result", result_q, e);
		chk("temp", temp_res_q, ch);
		@(posedge mclk);
	endtask
	task automatic t_regs;
		rchk(8'h08, 24'h000000);
		wreg(8'h08, 24'habcdef);
		rchk(8'h08, 24'habcdef);
		wreg(8'h01, 24'hffffff);
		rchk(8'h01, 24'h000940);
		rchk(8'h3f, 24'h000000);
		$display("regs done");
	endtask
	task automatic t_src;
		wreg(8'h01, 24'h000000);
		meas(24'h010000, 24'h020000, 24'h123456, 24'h123456);
		wreg(8'h08, 24'h000000);
		wreg(8'h09, 24'h100000);
		wreg(8'h01, 24'h000040);
		meas(24'h010000, 24'h020000, 24'h000100, 24'h010100);
		wreg(8'h01, 24'h000140);
		meas(24'h010000, 24'h020000, 24'h000100, 24'h020100);
		rchk(8'h11, 24'h020100);
		rchk(8'h12, 24'h020000);
		wreg(8'h08, 24'h100000);
		wreg(8'h09, 24'h000000);
		wreg(8'h01, 24'h000040);
		meas(24'h010000, 24'h000000, 24'h100000, 24'h110000);
		$display("source done");
	endtask
	task automatic t_vpr;
		wreg(8'h08, 24'h000000);
		wreg(8'h09, 24'h100000);
		wreg(8'h01, 24'h000840);
		wreg(8'h07, 24'h080000);
		meas(24'h100000, 24'h000000, 24'h000000, 24'h080000);
		wreg(8'h07, 24'hf80000);
		rchk(8'h07, 24'hf80000);
		meas(24'h100000, 24'h000000, 24'h000000, 24'h180000);
		$display("resistor done");
	endtask
	task automatic t_rst;
		nrst <= 0;
		repeat (2) @(posedge mclk);
		nrst <= 1;
		@(posedge mclk);
		chk("reset result", result_q, 24'h000000);
		chk("reset temp", temp_res_q, 24'h000000);
		rchk(8'h01, 24'h000000);
		rchk(8'h08, 24'h000000);
		rchk(8'h09, 24'h000000);
		$display("reset done");
	endtask
	task automatic t_stat;
		wreg(8'h01, 24'h000040);
		cycle_end <= 1;
		@(posedge mclk);
		@(posedge mclk);
		cycle_end <= 0;
		rchk(8'h10, 24'h000003);
		repeat (4) @(posedge mclk);
		wreg(8'h10, 24'h000002);
		rchk(8'h10, 24'h000000);
		wreg(8'h08, 24'h7fffff);
		meas(24'h7fffff, 24'h030000, 24'h000100, 24'h0008ff);
		rchk(8'h10, 24'h000004);
		wreg(8'h10, 24'h000004);
		rchk(8'h10, 24'h000000);
		$display("status done");
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		nrst <= 1;
		@(posedge mclk);
		t_regs();
		t_src();
		t_vpr();
		t_rst();
		t_stat();
		summarize();
	end
endmodule // temp_drift_compensation_tb_top
`default_nettype wire
